// [tb/spi_host_model.sv]
/* Host model on the SPI pins, mode 0, three clocks each half period.
   Assumes the bench calls xfer and that clk_sys runs free. */
module spi_host_model (
	// Clock and pins
	input  wire logic clk_sys,
	input  wire logic miso_out,
	output logic      ce_n,
	output logic      sclk,
	output logic      mosi
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		ce_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
	end
	// Deselected data line toggles so a stale bit never looks valid
	always @(posedge clk_sys) begin
		if (ce_n)
			mosi <= ~mosi;
	end
	// ********
	// One frame: read flag, spare bit, address, word
	// ********
	task automatic xfer(input logic rd, input logic [5:0] a, input logic [15:0] d,
		output logic [15:0] q);
		logic [23:0] frame;
		frame = {rd, 1'b0, a, d};
		q = 16'h0000;
		@(posedge clk_sys);
		ce_n <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			@(posedge clk_sys);
			sclk <= 1'b0;
			mosi <= frame[i];
			repeat (3) @(posedge clk_sys);
			q = {q[14:0], miso_out};
			sclk <= 1'b1;
			repeat (2) @(posedge clk_sys);
		end
		repeat (2) @(posedge clk_sys);
		sclk <= 1'b0;
		ce_n <= 1'b1;
	endtask
endmodule

// [tb/transceiver_mode_clockout_regs_tb.sv]
/* Self-checking bench for the register group, driven by the SPI host model.
   Assumes the params header is on the include path. */
`include "xcvr_ctl_params.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
	$display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module transceiver_mode_clockout_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, nrst, ce_n, sclk, mosi, miso_out, miso_oe, irq_n, other_irq_request;
	logic stream_tx_finish_flag, stream_rx_finish_flag, ram_addr_fault_flag;
	logic arb_conflict_fault_flag, status_slot_addr, status_slot_arb, clock_out;
	logic gpio1_normal_out, gpio1_normal_oe, gpio2_normal_out, gpio2_normal_oe;
	logic xcvr_busy, crc_cca_valid, gpio1_out, gpio1_oe, gpio2_out, gpio2_oe;
	logic timer_load_pulse, timer_base_run, antenna_port_select, amplifier_enable;
	logic stream_mode_select, doze_active, hibernate_active;
	logic [23:0] timer_compare_one, timer_load_value;
	logic [2:0]  timer_prescale;
	logic [7:0]  xtal_trim;
	logic [31:0] exp_q[$], got_q[$], g, e, n;
	logic [15:0] rd, v, w[4];
	logic [3:0]  f;
	int          mismatches, num_checks, pulses;
	logic [15:0] rst[4] = '{`RST_RF_POWER_STREAM, `RST_AMPLIFIER, `RST_GPIO_CLOCK_TIMER,
		`RST_CLOCK_TRIM};
	logic [15:0] msk[4] = '{`WMASK_RF_POWER_STREAM, `WMASK_AMPLIFIER,
		`WMASK_GPIO_CLOCK_TIMER, `WMASK_CLOCK_TRIM};
	logic [31:0] half[8] = '{1, 1, 2, 4, 8, 128, 244, 488};
	transceiver_mode_clockout_regs transceiver_mode_clockout_regs_i (.*);
	spi_host_model spi_host_model_i (.*);
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	always @(negedge clk_sys) pulses += timer_load_pulse;
	initial forever begin
		wait (got_q.size() != 0);
		g = got_q.pop_front();
		e = exp_q.pop_front();
		`CHK(g, e)
	end
	initial begin
		#(100 * 60000);
		mismatches++;
		close_out();
	end
	// ********
	// Tasks
	// ********
	task automatic note(input logic [31:0] ex, input logic [31:0] got);
		exp_q.push_back(ex);
		got_q.push_back(got);
	endtask
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		spi_host_model_i.xfer(1'b0, a, d, rd);
		repeat (3) @(posedge clk_sys);
	endtask
	task automatic chk_rd(input logic [5:0] a, input logic [15:0] ex);
		spi_host_model_i.xfer(1'b1, a, 16'h0000, rd);
		note(ex, rd);
	endtask
	// Third run is whole even if the rate changed mid-count
	task automatic half_period(output logic [31:0] c);
		logic last;
		@(negedge clk_sys);
		repeat (3) begin
			last = clock_out;
			c = 0;
			while (clock_out === last && c < 1000) begin
				@(negedge clk_sys);
				c++;
			end
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ********
	// Main sequence
	// ********
	initial begin
		nrst = 1'b0;
		{stream_tx_finish_flag, stream_rx_finish_flag, ram_addr_fault_flag,
			arb_conflict_fault_flag, other_irq_request, xcvr_busy, crc_cca_valid} = 7'h00;
		{gpio1_normal_out, gpio1_normal_oe, gpio2_normal_out, gpio2_normal_oe} = 4'h0;
		timer_compare_one = 24'h000000;
		void'($urandom(32'h5b31b71f));
		repeat (8) @(posedge clk_sys);
		nrst <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			chk_rd(6'(7 + k), rst[k]);
			w[k] = 16'($urandom());
			wr(6'(7 + k), w[k]);
			chk_rd(6'(7 + k), (w[k] & msk[k]) | (rst[k] & ~msk[k]));
		end
		note({w[0][12], w[0][5]}, {antenna_port_select, stream_mode_select});
		note({w[1][15], w[2][2:0], w[3][15:8]},
			{amplifier_enable, timer_prescale, xtal_trim});
		wr(6'h0b, 16'($urandom()));
		chk_rd(6'h0b, 16'h0000);
		for (int i = 0; i < 16; i++) begin
			wr(`OFS_RF_POWER_STREAM_CONTROL, {8'h08, i[0], i[1], i[2], 5'h00});
			wr(`OFS_GPIO_CLOCK_TIMER_CONTROL, {8'h00, i[0], 7'h20});
			v = 16'($urandom());
			f = {i[3], ~i[3], v[1:0]};
			{stream_tx_finish_flag, stream_rx_finish_flag, ram_addr_fault_flag,
				arb_conflict_fault_flag} <= f;
			other_irq_request <= v[2] & i[0] & i[1];
			{gpio1_normal_oe, gpio2_normal_oe, gpio1_normal_out, gpio2_normal_out,
				xcvr_busy, crc_cca_valid} <= v[8:3];
			repeat (3) @(posedge clk_sys);
			note(!(v[2] & i[0] & i[1] | i[2] & (f[3] & i[0] | f[2] & i[1])), irq_n);
			note(i[2] ? f[3:2] : f[1:0], {status_slot_addr, status_slot_arb});
			note(i[0] ? {v[4:3], 2'b11} : {v[6:5], v[8:7]},
				{gpio1_out, gpio2_out, gpio1_oe, gpio2_oe});
		end
		timer_compare_one <= 24'($urandom());
		pulses = 0;
		for (int k = 0; k < 5; k++) begin
			wr(`OFS_RF_POWER_STREAM_CONTROL, (k == 1 || k > 2) ? 16'h8800 : 16'h0800);
			note(k > 2 ? 2 : (k > 0 ? 1 : 0), pulses);
		end
		note(timer_compare_one, timer_load_value);
		for (int c = 0; c < 8; c++) begin
			wr(`OFS_CLOCK_OUTPUT_TRIM_CONTROL, {13'h0fc0, c[2:0]});
			half_period(n);
			note(half[c], n);
		end
		wr(`OFS_CLOCK_OUTPUT_TRIM_CONTROL, 16'h7e01);
		wr(`OFS_RF_POWER_STREAM_CONTROL, 16'h0201);
		half_period(n);
		note(8, n);
		for (int s = 0; s < 3; s++) begin
			wr(`OFS_RF_POWER_STREAM_CONTROL, s == 2 ? 16'h0000 : 16'h0001 << s);
			wr(`OFS_GPIO_CLOCK_TIMER_CONTROL, s == 2 ? 16'h0000 : 16'h0020);
			repeat (200) @(posedge clk_sys);
			note(1, miso_oe);
			note({s == 0, s == 1, s != 1}, {doze_active, hibernate_active, timer_base_run});
			half_period(n);
			note({1'b0, 16'd1000}, {clock_out, n[15:0]});
		end
		wait (got_q.size() == 0);
		#1;
		close_out();
	end
endmodule

// [tb/xcvr_ctl_props.sv]
/* Port checker for the mode, power and clock-out register group.
   Assumes a bind onto the top module and a single clock domain. */
module xcvr_ctl_props (
	// Watched ports
	input wire logic clk_sys, nrst, ce_n, miso_out, miso_oe, timer_load_pulse,
	input wire logic stream_rx_finish_flag, ram_addr_fault_flag, other_irq_request,
	input wire logic irq_n, status_slot_addr, status_slot_arb, stream_mode_select,
	input wire logic hibernate_active, timer_base_run, clock_out
);
	// ********
	// Properties
	// ********
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	a_irq_quiet:
		assert property (!$past(other_irq_request) && !stream_mode_select |-> irq_n)
		else $error("irq low without request");
	a_irq_pending:
		assert property ($past(other_irq_request) |-> !irq_n)
		else $error("irq high with request pending");
	a_slot_packet:
		assert property (!stream_mode_select |-> status_slot_addr == $past(ram_addr_fault_flag))
		else $error("address slot wrong in packet mode");
	a_slot_stream:
		assert property (stream_mode_select |-> status_slot_arb == $past(stream_rx_finish_flag))
		else $error("arbitration slot wrong in stream mode");
	a_miso_idle:
		assert property (ce_n && $past(ce_n) |-> !miso_out)
		else $error("miso not low while deselected");
	a_miso_drive:
		assert property ((!ce_n) [*2] |-> miso_oe)
		else $error("miso not driven in frame");
	a_load_single:
		assert property (timer_load_pulse |=> !timer_load_pulse)
		else $error("load pulse longer than one cycle");
	a_hib_frozen:
		assert property (hibernate_active [*3] |-> !timer_base_run && !clock_out)
		else $error("time base or clock running in hibernate");
	c_load: cover property (timer_load_pulse);
	c_stream_slot: cover property (stream_mode_select && status_slot_addr);
	c_hibernate: cover property (hibernate_active && !timer_base_run);
endmodule

bind transceiver_mode_clockout_regs xcvr_ctl_props xcvr_ctl_props_i (.*);

// [verilog/clock_out_divider.sv]
/*
 * Reference clock output divider. The output is a flip-flop held low while not running.
 * Assumes clk_sys stands for the crystal reference.
 */
module clock_out_divider import xcvr_ctl_pkg::*; #(
	parameter int CNT_W = 10
) (
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	input  wire logic       run,
	input  wire logic [2:0] rate,
	output logic            clk_out_reg
);
`include "xcvr_ctl_params.svh"

	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] half;

	function automatic logic [CNT_W-1:0] half_period(input logic [2:0] code);
		case (code)
			3'h0: half_period = `HALF_DIV1;
			3'h1: half_period = `HALF_DIV2;
			3'h2: half_period = `HALF_DIV4;
			3'h3: half_period = `HALF_DIV8;
			3'h4: half_period = `HALF_DIV16;
			3'h5: half_period = `HALF_DIV256;
			3'h6: half_period = `HALF_DIV488;
			default: half_period = `HALF_DIV976;
		endcase
	endfunction

	assign half = half_period(rate);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			count_reg   <= '0;
			clk_out_reg <= 1'b0;
		end else if (!run) begin
			count_reg   <= '0;
			clk_out_reg <= 1'b0;
		end else if (count_reg + CNT_W'(1) >= half) begin
			// >= so a rate change to a faster code never overruns
			count_reg   <= '0;
			clk_out_reg <= ~clk_out_reg;
		end else begin
			count_reg <= count_reg + CNT_W'(1);
		end
	end

endmodule

// [verilog/spi_word_port.sv]
/*
 * SPI slave framing: one header byte (bit 7 read flag, bits 5-0 address), then a
 * 16-bit word MSB first. Samples on sclk rise, shifts out on sclk fall.
 * Assumes sclk, mosi and ce_n are synchronous to clk_sys and far slower than it.
 */
module spi_word_port import xcvr_ctl_pkg::*; (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	// Pins
	input  wire logic        ce_n,
	input  wire logic        sclk,
	input  wire logic        mosi,
	output logic             miso_reg,
	// Register side
	output logic [5:0]       addr_reg,
	output logic             addr_pulse_reg,
	input  wire logic [15:0] rd_data,
	output logic             wr_pulse_reg,
	output logic [15:0]      wr_data_reg
);
`include "xcvr_ctl_params.svh"

	spi_state_t  state_reg;
	logic        sclk_reg;
	logic        read_reg;
	logic [4:0]  count_reg;
	logic [15:0] in_shift_reg;
	logic [15:0] out_shift_reg;
	logic        rise;
	logic        fall;
	logic [15:0] in_next;

	assign rise    = sclk & ~sclk_reg;
	assign fall    = ~sclk & sclk_reg;
	assign in_next = {in_shift_reg[14:0], mosi};

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_reg      <= SPI_IDLE;
			sclk_reg       <= 1'b0;
			read_reg       <= 1'b0;
			count_reg      <= 5'd0;
			in_shift_reg   <= 16'h0000;
			out_shift_reg  <= 16'h0000;
			miso_reg       <= 1'b0;
			addr_reg       <= 6'h00;
			addr_pulse_reg <= 1'b0;
			wr_pulse_reg   <= 1'b0;
			wr_data_reg    <= 16'h0000;
		end else begin
			sclk_reg       <= sclk;
			addr_pulse_reg <= 1'b0;
			wr_pulse_reg   <= 1'b0;
			if (ce_n) begin
				// Dropping chip select aborts any partial frame
				state_reg     <= SPI_IDLE;
				count_reg     <= 5'd0;
				out_shift_reg <= 16'h0000;
				miso_reg      <= 1'b0;
			end else begin
				if (state_reg == SPI_IDLE)
					state_reg <= SPI_ADDR;
				if (rise && state_reg != SPI_IDLE) begin
					in_shift_reg <= in_next;
					count_reg    <= count_reg + 5'd1;
					if (count_reg + 5'd1 == `SPI_ADDR_BITS) begin
						state_reg      <= SPI_DATA;
						read_reg       <= in_next[7];
						addr_reg       <= in_next[5:0];
						addr_pulse_reg <= 1'b1;
					end
					if (count_reg + 5'd1 == `SPI_FRAME_BITS) begin
						state_reg    <= SPI_ADDR;
						count_reg    <= 5'd0;
						wr_data_reg  <= in_next;
						wr_pulse_reg <= ~read_reg;
					end
				end
				if (addr_pulse_reg && read_reg)
					out_shift_reg <= rd_data;
				else if (fall && state_reg == SPI_DATA) begin
					miso_reg      <= out_shift_reg[15];
					out_shift_reg <= {out_shift_reg[14:0], 1'b0};
				end
			end
		end
	end

endmodule

// [verilog/transceiver_mode_clockout_regs.sv]
/*
 * Mode, power, stream and clock-out control register group reached over SPI.
 * Assumes interrupt status flags are held sticky outside and cleared there by the host;
 * the event timer, GPIO data path and RF front end sit outside and use these outputs.
 */

// What this block does
// RULE1: Control B bit 12 one selects single RF port; zero, default, dual port.
// RULE2: Control B bit 11 one floats serial output when deselected; zero drives low.
// RULE3: Host should clear the serial float bit before entering low power modes.
// RULE4: Clock output stops 128 cycles after doze request unless clock-in-doze set.
// RULE5: In doze the clock output runs at 1 MHz or slower only.
// RULE6: Control B bit 7 gates stream transmit finish onto the interrupt pin.
// RULE7: In stream mode transmit finish replaces the buffer address fault flag.
// RULE8: Control B bit 6 gates stream receive finish onto the interrupt pin.
// RULE9: In stream mode receive finish replaces the arbitration conflict fault flag.
// RULE10: Control B bit 5 selects packet mode at zero, stream mode at one.
// RULE11: Control B bit 1 enters hibernate with time base stopped; clear resumes.
// RULE12: Control B bit 0 enters doze with time base running; clear resumes.
// RULE13: Amplifier register bit 15 enables transmit amplifier, default on; rest reserved.
// RULE14: Control C bit 7 turns GPIO1 and GPIO2 into busy and result status.
// RULE15: Control C bit 5 enables clock output, default on; zero holds it low.
// RULE16: Control C bits 2 to 0 select the event timer base clock prescale.
// RULE17: Clock control bits 2 to 0 pick output divider from the reference.
// RULE18: Clock control bits 15 to 8 hold crystal trim, default 0x7E.
// RULE19: Event timer loads from compare-one only on a zero-to-one load bit write.
// RULE20: Interrupt pin asserts while any enabled flag stays set.
// RULE21: Reserved bits read back defaults and writes to them change nothing.
module transceiver_mode_clockout_regs import xcvr_ctl_pkg::*; (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	// SPI pins
	input  wire logic        ce_n,
	input  wire logic        sclk,
	input  wire logic        mosi,
	output logic             miso_out,
	output logic             miso_oe,
	// Interrupt sources, sticky outside
	input  wire logic        stream_tx_finish_flag,
	input  wire logic        stream_rx_finish_flag,
	input  wire logic        ram_addr_fault_flag,
	input  wire logic        arb_conflict_fault_flag,
	input  wire logic        other_irq_request,
	// Interrupt pin and status slots
	output logic             irq_n,
	output logic             status_slot_addr,
	output logic             status_slot_arb,
	// GPIO1 and GPIO2 pin drive
	input  wire logic        gpio1_normal_out,
	input  wire logic        gpio1_normal_oe,
	input  wire logic        gpio2_normal_out,
	input  wire logic        gpio2_normal_oe,
	input  wire logic        xcvr_busy,
	input  wire logic        crc_cca_valid,
	output logic             gpio1_out,
	output logic             gpio1_oe,
	output logic             gpio2_out,
	output logic             gpio2_oe,
	// Event timer
	input  wire logic [23:0] timer_compare_one,
	output logic             timer_load_pulse,
	output logic [23:0]      timer_load_value,
	output logic [2:0]       timer_prescale,
	output logic             timer_base_run,
	// RF and power
	output logic             antenna_port_select,
	output logic             amplifier_enable,
	output logic             stream_mode_select,
	output logic             doze_active,
	output logic             hibernate_active,
	// Reference clock
	output logic             clock_out,
	output logic [7:0]       xtal_trim
);
`include "xcvr_ctl_params.svh"

	// ****************************************
	// Declarations
	// ****************************************
	logic [15:0] rf_power_stream_control_reg;
	logic [15:0] transmit_amplifier_enable_reg;
	logic [15:0] gpio_clock_timer_control_reg;
	logic [15:0] clock_output_trim_control_reg;
	logic [5:0]  spi_addr;
	logic        spi_addr_pulse;
	logic        spi_wr_pulse;
	logic [15:0] spi_wr_data;
	logic [15:0] rd_data;
	logic        spi_miso;
	logic [3:0]  reg_sel;
	logic        wr_ctl_b;
	logic [15:0] ctl_b_next;
	power_mode_t power_next;
	logic [7:0]  doze_count_reg;
	logic        clock_run_reg;
	logic [2:0]  rate_reg;
	logic        clock_run_next;
	logic [2:0]  rate_next;
	logic        irq_next;

	// ****************************************
	// Address decode
	// ****************************************
	function automatic logic [3:0] reg_select(input logic [5:0] addr);
		if (addr == `OFS_RF_POWER_STREAM_CONTROL)
			reg_select = 4'b0001;
		else if (addr == `OFS_TRANSMIT_AMPLIFIER_ENABLE)
			reg_select = 4'b0010;
		else if (addr == `OFS_GPIO_CLOCK_TIMER_CONTROL)
			reg_select = 4'b0100;
		else if (addr == `OFS_CLOCK_OUTPUT_TRIM_CONTROL)
			reg_select = 4'b1000;
		else
			reg_select = 4'b0000;
	endfunction

	// Keeps reserved bits at their default whatever is written
	function automatic logic [15:0] merge(input logic [15:0] data, input logic [15:0] wmask,
		input logic [15:0] rstval);
		merge = (data & wmask) | (rstval & ~wmask);
	endfunction

	// ****************************************
	// SPI port
	// ****************************************
	spi_word_port u_spi (
		.clk_sys        (clk_sys),
		.nrst           (nrst),
		.ce_n           (ce_n),
		.sclk           (sclk),
		.mosi           (mosi),
		.miso_reg       (spi_miso),
		.addr_reg       (spi_addr),
		.addr_pulse_reg (spi_addr_pulse),
		.rd_data        (rd_data),
		.wr_pulse_reg   (spi_wr_pulse),
		.wr_data_reg    (spi_wr_data)
	);

	assign miso_out = spi_miso;
	assign reg_sel  = reg_select(spi_addr);

	// Unmapped addresses read as zero
	always_comb begin
		rd_data = 16'h0000;
		case (reg_select(spi_addr))
			4'b0001: rd_data = rf_power_stream_control_reg;
			4'b0010: rd_data = transmit_amplifier_enable_reg;
			4'b0100: rd_data = gpio_clock_timer_control_reg;
			4'b1000: rd_data = clock_output_trim_control_reg;
			default: rd_data = 16'h0000;
		endcase
	end

	// Serial output floats or drives low while deselected
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			miso_oe <= 1'b0;
		else
			miso_oe <= ~ce_n | ~rf_power_stream_control_reg[`BIT_MISO_FLOAT]; // see RULE2
	end

	// ****************************************
	// Register writes
	// ****************************************
	assign wr_ctl_b   = spi_wr_pulse & reg_sel[0];
	assign ctl_b_next = merge(spi_wr_data, `WMASK_RF_POWER_STREAM, `RST_RF_POWER_STREAM);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			rf_power_stream_control_reg <= `RST_RF_POWER_STREAM;
		else if (wr_ctl_b)
			rf_power_stream_control_reg <= ctl_b_next; // see RULE21
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			transmit_amplifier_enable_reg <= `RST_AMPLIFIER;
		else if (spi_wr_pulse && reg_sel[1])
			transmit_amplifier_enable_reg <= merge(spi_wr_data, `WMASK_AMPLIFIER,
				`RST_AMPLIFIER); // see RULE13
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			gpio_clock_timer_control_reg <= `RST_GPIO_CLOCK_TIMER;
		else if (spi_wr_pulse && reg_sel[2])
			gpio_clock_timer_control_reg <= merge(spi_wr_data, `WMASK_GPIO_CLOCK_TIMER,
				`RST_GPIO_CLOCK_TIMER); // see RULE21
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			clock_output_trim_control_reg <= `RST_CLOCK_TRIM;
		else if (spi_wr_pulse && reg_sel[3])
			clock_output_trim_control_reg <= merge(spi_wr_data, `WMASK_CLOCK_TRIM,
				`RST_CLOCK_TRIM); // see RULE21
	end

	// ****************************************
	// Event timer load
	// ****************************************
	// Only the rising write loads, so a held one never reloads
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			timer_load_pulse <= 1'b0;
			timer_load_value <= 24'h000000;
		end else begin
			timer_load_pulse <= wr_ctl_b & ctl_b_next[`BIT_TIMER_LOAD]
				& ~rf_power_stream_control_reg[`BIT_TIMER_LOAD]; // see RULE19
			if (wr_ctl_b && ctl_b_next[`BIT_TIMER_LOAD]
				&& !rf_power_stream_control_reg[`BIT_TIMER_LOAD])
				timer_load_value <= timer_compare_one; // see RULE19
		end
	end

	// ****************************************
	// Power modes
	// ****************************************
	// Hibernate outranks doze; the mode follows the two bits with no other state
	always_comb begin
		if (rf_power_stream_control_reg[`BIT_HIBERNATE])
			power_next = PWR_HIBERNATE; // see RULE11
		else if (rf_power_stream_control_reg[`BIT_DOZE])
			power_next = PWR_DOZE; // see RULE12
		else
			power_next = PWR_NORMAL;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			doze_active      <= 1'b0;
			hibernate_active <= 1'b0;
			timer_base_run   <= 1'b1;
		end else begin
			doze_active      <= power_next == PWR_DOZE; // see RULE12
			hibernate_active <= power_next == PWR_HIBERNATE; // see RULE11
			timer_base_run   <= power_next != PWR_HIBERNATE; // see RULE11
		end
	end

	// Counts reference cycles from the doze request write
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			doze_count_reg <= 8'h00;
		else if (!rf_power_stream_control_reg[`BIT_DOZE])
			doze_count_reg <= 8'h00;
		else if (doze_count_reg != `DOZE_STOP_CYCLES)
			doze_count_reg <= doze_count_reg + 8'h01; // see RULE4
	end

	// ****************************************
	// Reference clock output
	// ****************************************
	always_comb begin
		clock_run_next = gpio_clock_timer_control_reg[`BIT_CLKOUT_ENABLE]; // see RULE15
		rate_next      = clock_output_trim_control_reg[`RATE_LSB +: 3]; // see RULE17
		if (power_next == PWR_HIBERNATE)
			clock_run_next = 1'b0;
		if (rf_power_stream_control_reg[`BIT_DOZE]) begin
			if (!rf_power_stream_control_reg[`BIT_CLKOUT_IN_DOZE]
				&& doze_count_reg == `DOZE_STOP_CYCLES)
				clock_run_next = 1'b0; // see RULE4
			// Faster codes are clamped rather than refused
			if (rate_next < `RATE_DOZE_FASTEST)
				rate_next = `RATE_DOZE_FASTEST; // see RULE5
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			clock_run_reg <= 1'b0;
			rate_reg      <= 3'h6;
		end else begin
			clock_run_reg <= clock_run_next;
			rate_reg      <= rate_next;
		end
	end

	clock_out_divider #(
		.CNT_W (10)
	) u_clkdiv (
		.clk_sys     (clk_sys),
		.nrst        (nrst),
		.run         (clock_run_reg),
		.rate        (rate_reg),
		.clk_out_reg (clock_out)
	);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			xtal_trim <= 8'h7e;
		else
			xtal_trim <= clock_output_trim_control_reg[`TRIM_LSB +: 8]; // see RULE18
	end

	// ****************************************
	// Interrupt steering
	// ****************************************
	always_comb begin
		irq_next = other_irq_request;
		if (rf_power_stream_control_reg[`BIT_STREAM_SELECT]) begin
			if (stream_tx_finish_flag && rf_power_stream_control_reg[`BIT_TX_FINISH_MASK])
				irq_next = 1'b1; // see RULE6
			if (stream_rx_finish_flag && rf_power_stream_control_reg[`BIT_RX_FINISH_MASK])
				irq_next = 1'b1; // see RULE8
		end
	end

	// Pin follows the held flags as enabled, so it goes high again once the host clears them or their enable bits
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			irq_n <= 1'b1;
		else
			irq_n <= ~irq_next; // see RULE20
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			status_slot_addr <= 1'b0;
			status_slot_arb  <= 1'b0;
		end else if (rf_power_stream_control_reg[`BIT_STREAM_SELECT]) begin
			status_slot_addr <= stream_tx_finish_flag; // see RULE7
			status_slot_arb  <= stream_rx_finish_flag; // see RULE9
		end else begin
			status_slot_addr <= ram_addr_fault_flag;
			status_slot_arb  <= arb_conflict_fault_flag;
		end
	end

	// ****************************************
	// Mode and pin outputs
	// ****************************************
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			antenna_port_select <= 1'b0;
			amplifier_enable    <= 1'b1;
			stream_mode_select  <= 1'b0;
			timer_prescale      <= 3'h0;
		end else begin
			antenna_port_select <= rf_power_stream_control_reg[`BIT_ANTENNA_PORT]; // see RULE1
			amplifier_enable    <= transmit_amplifier_enable_reg[`BIT_AMPLIFIER_ENABLE]; // see RULE13
			stream_mode_select  <= rf_power_stream_control_reg[`BIT_STREAM_SELECT]; // see RULE10
			timer_prescale      <= gpio_clock_timer_control_reg[2:0]; // see RULE16
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			gpio1_out <= 1'b0;
			gpio1_oe  <= 1'b0;
			gpio2_out <= 1'b0;
			gpio2_oe  <= 1'b0;
		end else if (gpio_clock_timer_control_reg[`BIT_GPIO_ALT]) begin
			gpio1_out <= xcvr_busy; // see RULE14
			gpio1_oe  <= 1'b1;
			gpio2_out <= crc_cca_valid; // see RULE14
			gpio2_oe  <= 1'b1;
		end else begin
			gpio1_out <= gpio1_normal_out;
			gpio1_oe  <= gpio1_normal_oe;
			gpio2_out <= gpio2_normal_out;
			gpio2_oe  <= gpio2_normal_oe;
		end
	end

endmodule

// [verilog/xcvr_ctl_params.svh]
/*
 * Offsets, field positions, reset values, write masks and counts of the mode, power and
 * clock-out control register group.
 * Assumes inclusion by bare name; holds definitions only.
 */
`ifndef XCVR_CTL_PARAMS_SVH
`define XCVR_CTL_PARAMS_SVH

// ****************************************
// Register offsets (SPI word addresses)
// ****************************************
`define OFS_RF_POWER_STREAM_CONTROL   6'h07
`define OFS_TRANSMIT_AMPLIFIER_ENABLE 6'h08
`define OFS_GPIO_CLOCK_TIMER_CONTROL  6'h09
`define OFS_CLOCK_OUTPUT_TRIM_CONTROL 6'h0a

// ****************************************
// Reset values and writable bits
// ****************************************
`define RST_RF_POWER_STREAM   16'h0800
`define WMASK_RF_POWER_STREAM 16'h9ae3
`define RST_AMPLIFIER         16'h8000
`define WMASK_AMPLIFIER       16'h8000
`define RST_GPIO_CLOCK_TIMER  16'h0020
`define WMASK_GPIO_CLOCK_TIMER 16'h00a7
`define RST_CLOCK_TRIM        16'h7e06
`define WMASK_CLOCK_TRIM      16'hff07

// ****************************************
// Field positions
// ****************************************
`define BIT_TIMER_LOAD        15
`define BIT_ANTENNA_PORT      12
`define BIT_MISO_FLOAT        11
`define BIT_CLKOUT_IN_DOZE    9
`define BIT_TX_FINISH_MASK    7
`define BIT_RX_FINISH_MASK    6
`define BIT_STREAM_SELECT     5
`define BIT_HIBERNATE         1
`define BIT_DOZE              0
`define BIT_AMPLIFIER_ENABLE  15
`define BIT_GPIO_ALT          7
`define BIT_CLKOUT_ENABLE     5
`define RATE_LSB              0
`define TRIM_LSB              8

// ****************************************
// Counts
// ****************************************
`define DOZE_STOP_CYCLES      8'd128
`define RATE_DOZE_FASTEST     3'h4
`define SPI_ADDR_BITS         5'd8
`define SPI_FRAME_BITS        5'd24
`define HALF_DIV1             10'd1
`define HALF_DIV2             10'd1
`define HALF_DIV4             10'd2
`define HALF_DIV8             10'd4
`define HALF_DIV16            10'd8
`define HALF_DIV256           10'd128
`define HALF_DIV488           10'd244
`define HALF_DIV976           10'd488

`endif

// [verilog/xcvr_ctl_pkg.sv]
/*
 * Types shared by the control register group.
 * Assumes the params header for all numeric constants.
 */
package xcvr_ctl_pkg;

	// Gray coded along idle -> address -> data
	typedef enum logic [1:0] {
		SPI_IDLE = 2'b00,
		SPI_ADDR = 2'b01,
		SPI_DATA = 2'b11
	} spi_state_t;

	// Gray coded along normal -> doze -> hibernate
	typedef enum logic [1:0] {
		PWR_NORMAL    = 2'b00,
		PWR_DOZE      = 2'b01,
		PWR_HIBERNATE = 2'b11
	} power_mode_t;

endpackage
